// [bench/sec_sync_source.sv]
// Partner model: external sync source and the lock detectors of both loops.
// Assumes bench requests change just after a rising clock edge.
`timescale 1ns/100ps
module sec_sync_source #(
   parameter int LOCK_LAG = 3
)(
   input  wire logic mclk_i,
   input  wire logic pin_req_i,
   input  wire logic lock_req_i,
   input  wire logic lock_sel_i,
   output logic      sync_pin_o,
   output logic      loop1_lock_o,
   output logic      loop2_lock_o
);
   int lag = 0;
   always_ff @(posedge mclk_i) begin
      sync_pin_o   <= pin_req_i;
      lag          <= lock_req_i ? ((lag < LOCK_LAG) ? lag + 1 : lag) : 0;
      // Lock shows only after the loop has had time to settle
      loop1_lock_o <= (lag == LOCK_LAG) & ~lock_sel_i;
      loop2_lock_o <= (lag == LOCK_LAG) & lock_sel_i;
   end
endmodule : sec_sync_source

// [bench/sync_event_control_bench.sv]
// Self-checking bench of the sync event control block.
// Assumes sec_top with its Avalon-MM port and the sync source model.
`timescale 1ns/100ps
`include "sec_defines.svh"
module sync_event_control_bench;
   import sec_pkg::*;
   localparam int MIN_CYC = 4;
   logic        mclk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [10:0] avs_address_i = 11'h000;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [3:0]  avs_byteenable_i = 4'h0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic [31:0] rdq;
   logic        avs_waitrequest_o;
   logic        sync_pin_i;
   logic        loop1_lock_i;
   logic        loop2_lock_i;
   logic        sync_assert_o;
   logic        sysref_resync_o;
   logic [6:0]  output_resync_o;
   logic        pulser_start_o;
   logic [7:0]  pulse_burst_count_o;
   logic        sysref_path_clear_o;
   logic        sysref_power_down_o;
   logic [2:0]  ref_auto_enable_o;
   logic [2:0]  ref_buffer_cmos_o;
   logic        pin_req = 1'b0;
   logic        lock_req = 1'b0;
   logic        lock_sel = 1'b0;
   int          mismatches = 0;
   int          comparisons = 0;
   int          pulses = 0;
   int          p0;
   int          n;

   always #5 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (pulser_start_o === 1'b1) pulses <= pulses + 1;

   sec_sync_source src_u (.mclk_i(mclk_i), .pin_req_i(pin_req), .lock_req_i(lock_req), .lock_sel_i(lock_sel),
      .sync_pin_o(sync_pin_i), .loop1_lock_o(loop1_lock_i), .loop2_lock_o(loop2_lock_i));

   sec_top #(.MIN_CYC(MIN_CYC)) dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .sync_pin_i(sync_pin_i), .loop1_lock_i(loop1_lock_i), .loop2_lock_i(loop2_lock_i),
      .sync_assert_o(sync_assert_o), .sysref_resync_o(sysref_resync_o), .output_resync_o(output_resync_o),
      .pulser_start_o(pulser_start_o), .pulse_burst_count_o(pulse_burst_count_o),
      .sysref_path_clear_o(sysref_path_clear_o), .sysref_power_down_o(sysref_power_down_o),
      .ref_auto_enable_o(ref_auto_enable_o), .ref_buffer_cmos_o(ref_buffer_cmos_o));

   task finish_test;
      if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test

   task cmp_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_word

   task cmp_port(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp_port

   // Holds the request until waitrequest is sampled low, then releases it
   task bus(input logic wr, input logic [8:0] idx, input logic [7:0] d, output logic [31:0] q);
      int k;
      @(posedge mclk_i);
      avs_address_i    <= {idx, 2'b00};
      avs_writedata_i  <= {24'h0, d};
      avs_byteenable_i <= 4'h1;
      avs_write_i      <= wr;
      avs_read_i       <= ~wr;
      k = 0;
      do begin
         @(posedge mclk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 50);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      if (k >= 50) begin
         mismatches++;
         finish_test();
      end
   endtask : bus

   task wr(input logic [8:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d, rdq);
   endtask : wr

   task rd_chk(input logic [8:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00, rdq);
      cmp_word(rdq, exp);
   endtask : rd_chk

   task wait_sync(input logic exp);
      int k;
      k = 0;
      while (sync_assert_o !== exp && k < 40) begin
         @(posedge mclk_i);
         k++;
      end
      cmp_port({7'h0, sync_assert_o}, {7'h0, exp});
      if (k >= 40) begin
         mismatches++;
         finish_test();
      end
   endtask : wait_sync

   task stay(input logic exp, input int cyc);
      repeat (cyc) begin
         @(posedge mclk_i);
         cmp_port({7'h0, sync_assert_o}, {7'h0, exp});
      end
   endtask : stay

   initial begin
      repeat (12) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      cmp_port({7'h0, sysref_path_clear_o}, 8'h01);
      cmp_port({5'h0, ref_auto_enable_o}, 8'h03);
      cmp_port({5'h0, ref_buffer_cmos_o}, 8'h00);
      cmp_port({7'h0, sysref_power_down_o}, 8'h01);
      rd_chk(`SEC_IDX_GEN, 32'h91);
      rd_chk(`SEC_IDX_EXEMPT, 32'h0);
      rd_chk(`SEC_IDX_FIXED, 32'h0);
      rd_chk(`SEC_IDX_REF, 32'h18);
      rd_chk(`SEC_IDX_PWR, 32'h04);
      rd_chk(9'h100, 32'h0);
      wr(`SEC_IDX_FIXED, 8'h7f);
      rd_chk(`SEC_IDX_FIXED, 32'h7f);
      wr(`SEC_IDX_REF, 8'hea);
      rd_chk(`SEC_IDX_REF, 32'h2a);
      cmp_port({5'h0, ref_auto_enable_o}, 8'h05);
      cmp_port({5'h0, ref_buffer_cmos_o}, 8'h02);
      wr(`SEC_IDX_GEN, 8'h11);
      wr(`SEC_IDX_EXEMPT, 8'h85);
      cmp_port({7'h0, sysref_path_clear_o}, 8'h00);
      pin_req <= 1'b1;
      stay(1'b0, 8);
      wr(`SEC_IDX_PWR, 8'h00);
      wait_sync(1'b1);
      stay(1'b1, 12);
      rd_chk(`SEC_IDX_STATUS, 32'h09);
      cmp_port({7'h0, sysref_power_down_o}, 8'h00);
      cmp_port({7'h0, sysref_resync_o}, 8'h00);
      cmp_port({1'b0, output_resync_o}, 8'h7a);
      wr(`SEC_IDX_GEN, 8'h31);
      wait_sync(1'b0);
      pin_req <= 1'b0;
      wait_sync(1'b1);
      wr(`SEC_IDX_GEN, 8'h21);
      wait_sync(1'b0);
      stay(1'b0, 6);
      wr(`SEC_IDX_GEN, 8'h30);
      stay(1'b0, 8);
      wr(`SEC_IDX_GEN, 8'h51);
      pin_req <= 1'b1;
      wait_sync(1'b1);
      n = 0;
      while (sync_assert_o === 1'b1 && n < 40) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= 40) begin
         mismatches++;
         finish_test();
      end
      cmp_port(8'(n), 8'(MIN_CYC));
      pin_req <= 1'b0;
      wr(`SEC_IDX_GEN, 8'h15);
      wait_sync(1'b1);
      lock_req <= 1'b1;
      wait_sync(1'b0);
      lock_req <= 1'b0;
      lock_sel <= 1'b1;
      wr(`SEC_IDX_GEN, 8'h19);
      wait_sync(1'b1);
      lock_req <= 1'b1;
      wait_sync(1'b0);
      wr(`SEC_IDX_GEN, 8'h12);
      p0 = pulses;
      pin_req <= 1'b1;
      repeat (10) @(posedge mclk_i);
      cmp_port(8'(pulses - p0), 8'h01);
      pin_req <= 1'b0;
      wr(`SEC_IDX_GEN, 8'h13);
      p0 = pulses;
      wr(`SEC_IDX_PCNT, 8'h05);
      repeat (4) @(posedge mclk_i);
      cmp_port(8'(pulses - p0), 8'h01);
      cmp_port(pulse_burst_count_o, 8'h05);
      finish_test();
   end
endmodule : sync_event_control_bench

// [core/sec_defines.svh]
// Constants of the sync event control block: register indices, fields, resets, timing.
// Assumes a 100 MHz device clock and a 32-bit Avalon-MM register port.
// How it works
// [R1] Sysref path clear bit powers up set; software clears it after setup.
// [R2] Edge mode off: sync level holds the affected outputs while asserted.
// [R3] Edge mode on: rising sync edge resyncs outputs for a minimum time.
// [R4] Pin invert bit flips the sync pin before it is interpreted.
// [R5] Sync enable bit, reset one, turns all sync functionality off when zero.
// [R6] Loop2 qualification holds sync asserted until loop2 lock detect is one.
// [R7] Loop1 qualification holds sync asserted until loop1 lock detect is one.
// [R8] Source zero blocks pin and both lock flags from making sync events.
// [R9] Source one, reset value, makes sync from pin or enabled lock flags.
// [R10] Source two sends pin or lock-flag triggers to the pulser.
// [R11] Source three starts the pulser on each write of the burst count.
// [R12] Sysref exemption keeps sysref clocks running through sync events.
// [R13] Per-output exemption keeps that device clock running through sync and sysref.
// [R14] Software always writes 127 to the fixed slot, which resets to zero.
// [R15] Reference auto-enable bits admit inputs 2..0 to automatic switching.
// [R16] Buffer type bits choose bipolar at zero, CMOS at one.
// [R17] Software sets source three before a dynamic delay adjustment.
// [R18] Sysref power-down blocks sysref mode and every sync event.
// [R19] Sync pin passes a two-stage synchroniser before inversion and edge detect.
// [R20] Reserved reference control bits read zero and ignore writes.
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

`define SEC_IDX_PCNT    9'h13e
`define SEC_IDX_PWR     9'h140
`define SEC_IDX_GEN     9'h143
`define SEC_IDX_EXEMPT  9'h144
`define SEC_IDX_FIXED   9'h145
`define SEC_IDX_REF     9'h146
`define SEC_IDX_STATUS  9'h14f

`define SEC_GEN_RST     8'h91
`define SEC_EXEMPT_RST  8'h00
`define SEC_FIXED_RST   8'h00
`define SEC_REF_RST     8'h18
`define SEC_REF_MASK    8'h3f
`define SEC_PWR_RST     8'h04
`define SEC_PWR_MASK    8'h04
`define SEC_PCNT_RST    8'h00

`define SEC_B_CLR       7
`define SEC_B_EDGE      6
`define SEC_B_INV       5
`define SEC_B_EN        4
`define SEC_B_L2        3
`define SEC_B_L1        2
`define SEC_MODE_MSB    1
`define SEC_MODE_LSB    0
`define SEC_B_SR_EXEMPT 7
`define SEC_OUT_MSB     6
`define SEC_B_PD        2
`define SEC_EN_MSB      5
`define SEC_EN_LSB      3
`define SEC_TYPE_MSB    2
`define SEC_TYPE_LSB    0

`define SEC_CLK_NS      10
`define SEC_MIN_SYNC_NS 100

`endif

// [core/sec_pkg.sv]
// Types of the sync event control block.
// Assumes sec_defines.svh supplies the numeric constants.
package sec_pkg;
   typedef enum logic [1:0] {
      SEC_SRC_OFF        = 2'h0,
      SEC_SRC_PIN        = 2'h1,
      SEC_SRC_PULSER_PIN = 2'h2,
      SEC_SRC_PULSER_REG = 2'h3
   } sec_src_t;

   typedef enum logic [2:0] {
      SEC_ST_IDLE = 3'b001,
      SEC_ST_HOLD = 3'b010,
      SEC_ST_MIN  = 3'b100
   } sec_state_t;
endpackage : sec_pkg

// [core/sec_top.sv]
// Sync event control: register file, sync pin conditioning and resync decision.
// Assumes synchronous lock inputs and an Avalon-MM master holding each request.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "sec_defines.svh"

module sec_top
   import sec_pkg::*;
#(
   parameter int ADDR_W   = 11,
   parameter int MIN_CYC  = (`SEC_MIN_SYNC_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS
)(
   input  wire logic              mclk_i,
   input  wire logic              srst_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [3:0]        avs_byteenable_i,
   input  wire logic [31:0]       avs_writedata_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              sync_pin_i,
   input  wire logic              loop1_lock_i,
   input  wire logic              loop2_lock_i,
   output logic                   sync_assert_o,
   output logic                   sysref_resync_o,
   output logic [6:0]             output_resync_o,
   output logic                   pulser_start_o,
   output logic [7:0]             pulse_burst_count_o,
   output logic                   sysref_path_clear_o,
   output logic                   sysref_power_down_o,
   output logic [2:0]             ref_auto_enable_o,
   output logic [2:0]             ref_buffer_cmos_o
);

   localparam int CNT_W = $clog2(MIN_CYC + 1);
   localparam logic [CNT_W-1:0] MIN_LOAD = CNT_W'(MIN_CYC - 1);

   function automatic logic hit(input logic [ADDR_W-3:0] idx, input logic [ADDR_W-3:0] reg_idx);
      hit = (idx == reg_idx);
   endfunction : hit

   // Register storage
   logic [7:0]       gen_ctrl;
   logic [7:0]       exempt;
   logic [7:0]       fixed_slot;
   logic [7:0]       ref_ctrl;
   logic [7:0]       pwr_ctrl;
   logic [7:0]       pcnt;

   // Pin conditioning
   logic             pin_meta;
   logic             pin_sam;
   logic             pin_prev;
   logic             trig_prev;

   // Decision state
   sec_state_t       state;
   sec_state_t       next_state;
   logic [CNT_W-1:0] min_cnt;
   logic [CNT_W-1:0] next_min_cnt;

   // Bus decode
   wire [ADDR_W-3:0] idx      = avs_address_i[ADDR_W-1:2];
   wire              req      = avs_read_i | avs_write_i;
   wire              wr_fire  = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
   wire [7:0]        wdat     = avs_writedata_i[7:0];
   wire              wr_gen   = wr_fire & hit(idx, `SEC_IDX_GEN);
   wire              wr_exm   = wr_fire & hit(idx, `SEC_IDX_EXEMPT);
   wire              wr_fix   = wr_fire & hit(idx, `SEC_IDX_FIXED);
   wire              wr_ref   = wr_fire & hit(idx, `SEC_IDX_REF);
   wire              wr_pwr   = wr_fire & hit(idx, `SEC_IDX_PWR);
   wire              wr_pcnt  = wr_fire & hit(idx, `SEC_IDX_PCNT);

   // Control fields
   wire              edge_mode = gen_ctrl[`SEC_B_EDGE];
   wire              pin_inv   = gen_ctrl[`SEC_B_INV];
   wire              hold_l2   = gen_ctrl[`SEC_B_L2];
   wire              hold_l1   = gen_ctrl[`SEC_B_L1];
   wire sec_src_t    src       = sec_src_t'(gen_ctrl[`SEC_MODE_MSB:`SEC_MODE_LSB]);
   wire              sync_ok   = gen_ctrl[`SEC_B_EN] & ~pwr_ctrl[`SEC_B_PD]; // [R5] [R18]

   // Sync request terms
   wire              pin_level = pin_sam ^ pin_inv;                         // [R4] [R19]
   wire              pin_last  = pin_prev ^ pin_inv;
   wire              pin_rise  = pin_level & ~pin_last;
   wire              lock_req  = (hold_l1 & ~loop1_lock_i) | (hold_l2 & ~loop2_lock_i); // [R6] [R7]
   wire              level_req = (~edge_mode & pin_level) | lock_req;       // [R2]
   wire              start_req = edge_mode & pin_rise;                      // [R3]
   wire              trig      = pin_level | lock_req;
   wire              trig_rise = trig & ~trig_prev;
   wire              go        = sync_ok & (src == SEC_SRC_PIN);            // [R8] [R9]
   wire              next_active = (next_state != SEC_ST_IDLE);
   wire              next_pulse  = sync_ok & (((src == SEC_SRC_PULSER_PIN) & trig_rise)  // [R10]
                                            | ((src == SEC_SRC_PULSER_REG) & wr_pcnt));  // [R11]

   // Read mux
   wire [7:0]        status  = {4'h0, pin_level, loop2_lock_i, loop1_lock_i, sync_assert_o};
   wire [7:0]        rd_mux  = hit(idx, `SEC_IDX_GEN)    ? gen_ctrl   :
                               hit(idx, `SEC_IDX_EXEMPT) ? exempt     :
                               hit(idx, `SEC_IDX_FIXED)  ? fixed_slot :
                               hit(idx, `SEC_IDX_REF)    ? ref_ctrl   :  // [R20]
                               hit(idx, `SEC_IDX_PWR)    ? pwr_ctrl   :
                               hit(idx, `SEC_IDX_PCNT)   ? pcnt       :
                               hit(idx, `SEC_IDX_STATUS) ? status     : 8'h00;

   // One wait cycle per access; writes land at the edge that sees waitrequest low
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
      end else begin
         avs_waitrequest_o <= ~(req & avs_waitrequest_o);
         if (req & avs_waitrequest_o) begin
            avs_readdata_o <= {24'h00_0000, rd_mux};
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         gen_ctrl   <= `SEC_GEN_RST;                                        // [R1] [R5] [R9]
         exempt     <= `SEC_EXEMPT_RST;
         fixed_slot <= `SEC_FIXED_RST;                                      // [R14]
         ref_ctrl   <= `SEC_REF_RST;
         pwr_ctrl   <= `SEC_PWR_RST;
         pcnt       <= `SEC_PCNT_RST;
      end else begin
         if (wr_gen) gen_ctrl <= wdat;
         if (wr_exm) exempt <= wdat;
         if (wr_fix) fixed_slot <= wdat;
         if (wr_ref) ref_ctrl <= wdat & `SEC_REF_MASK;                       // [R20]
         if (wr_pwr) pwr_ctrl <= wdat & `SEC_PWR_MASK;
         if (wr_pcnt) pcnt <= wdat;
      end
   end

   // Two-stage synchroniser, then history flops for pin and trigger edge detection
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         pin_meta  <= 1'b0;
         pin_sam   <= 1'b0;
         pin_prev  <= 1'b0;
         trig_prev <= 1'b0;
      end else begin
         pin_meta  <= sync_pin_i;                                           // [R19]
         pin_sam   <= pin_meta;
         pin_prev  <= pin_sam;
         trig_prev <= trig;
      end
   end

   // Hold follows the level; a rising edge gives at least MIN_CYC cycles
   always_comb begin
      next_state   = state;
      next_min_cnt = min_cnt;
      case (state)
         SEC_ST_IDLE: begin
            if (go & start_req) begin
               next_state   = SEC_ST_MIN;                                   // [R3]
               next_min_cnt = MIN_LOAD;
            end else if (go & level_req) begin
               next_state = SEC_ST_HOLD;                                    // [R2]
            end
         end
         SEC_ST_HOLD: begin
            if (!go || !(level_req || start_req)) begin
               next_state = SEC_ST_IDLE;
            end else if (start_req) begin
               next_state   = SEC_ST_MIN;
               next_min_cnt = MIN_LOAD;
            end
         end
         SEC_ST_MIN: begin
            if (!go) begin
               next_state = SEC_ST_IDLE;
            end else if (start_req) begin
               next_min_cnt = MIN_LOAD;
            end else if (min_cnt != '0) begin
               next_min_cnt = min_cnt - CNT_W'(1);
            end else if (level_req) begin
               next_state = SEC_ST_HOLD;
            end else begin
               next_state = SEC_ST_IDLE;
            end
         end
         default: begin
            next_state = SEC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state   <= SEC_ST_IDLE;
         min_cnt <= '0;
      end else begin
         state   <= next_state;
         min_cnt <= next_min_cnt;
      end
   end

   // Registered outputs toward dividers, pulser and reference inputs
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sync_assert_o       <= 1'b0;
         sysref_resync_o     <= 1'b0;
         output_resync_o     <= 7'h00;
         pulser_start_o      <= 1'b0;
         pulse_burst_count_o <= `SEC_PCNT_RST;
         sysref_path_clear_o <= 1'b1;
         sysref_power_down_o <= 1'b1;
         ref_auto_enable_o   <= 3'h3;
         ref_buffer_cmos_o   <= 3'h0;
      end else begin
         sync_assert_o       <= next_active;
         sysref_resync_o     <= next_active & ~exempt[`SEC_B_SR_EXEMPT];     // [R12]
         output_resync_o     <= {7{next_active}} & ~exempt[`SEC_OUT_MSB:0];  // [R13]
         pulser_start_o      <= next_pulse;
         pulse_burst_count_o <= pcnt;
         sysref_path_clear_o <= gen_ctrl[`SEC_B_CLR];                       // [R1]
         sysref_power_down_o <= pwr_ctrl[`SEC_B_PD];                        // [R18]
         ref_auto_enable_o   <= ref_ctrl[`SEC_EN_MSB:`SEC_EN_LSB];           // [R15]
         ref_buffer_cmos_o   <= ref_ctrl[`SEC_TYPE_MSB:`SEC_TYPE_LSB];       // [R16]
      end
   end

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   // A rising edge loads the minimum window; the window then counts down without dropping
   sequence s_edge_armed;
      go && start_req;
   endsequence

   sequence s_min_loaded;
      sync_assert_o && (state == SEC_ST_MIN) && (min_cnt == MIN_LOAD);
   endsequence

   sequence s_min_running;
      go && (state == SEC_ST_MIN) && (min_cnt != '0);
   endsequence

   a_clear_reset: assert property (disable iff (1'b0) $past(srst_i) |-> sysref_path_clear_o) // [R1]
      else $error("sysref path clear not set out of reset");

   a_level_hold: assert property (go && !edge_mode && pin_level |=> sync_assert_o) // [R2]
      else $error("level sync did not hold outputs");

   a_edge_min: assert property (s_edge_armed |=> s_min_loaded) // [R3]
      else $error("edge sync did not load the minimum window");

   a_min_window: assert property (s_min_running |=> sync_assert_o && (state == SEC_ST_MIN)) // [R3]
      else $error("edge sync shorter than minimum");

   a_pin_invert: assert property (go && !edge_mode && !lock_req && (pin_sam == pin_inv)
                                  |=> !sync_assert_o || $past(state == SEC_ST_MIN)) // [R4]
      else $error("inverted pin level still asserted sync");

   a_disable_off: assert property (!sync_ok |=> !sync_assert_o && !pulser_start_o) // [R5]
      else $error("sync active while disabled or powered down");

   a_loop2_wait: assert property (go && hold_l2 && !loop2_lock_i |=> sync_assert_o) // [R6]
      else $error("sync not held for second loop lock");

   a_loop1_wait: assert property (go && hold_l1 && !loop1_lock_i |=> sync_assert_o) // [R7]
      else $error("sync not held for first loop lock");

   a_source_off: assert property (src == SEC_SRC_OFF |=> !sync_assert_o && !pulser_start_o) // [R8]
      else $error("source off still produced a sync event");

   a_pulser_pin: assert property (sync_ok && src == SEC_SRC_PULSER_PIN && trig_rise |=> pulser_start_o) // [R10]
      else $error("pin trigger did not start pulser");

   a_pulser_reg: assert property (sync_ok && src == SEC_SRC_PULSER_REG && wr_pcnt |=> pulser_start_o) // [R11]
      else $error("burst count write did not start pulser");

   a_sysref_exempt: assert property (##1 sysref_resync_o == (sync_assert_o && !$past(exempt[7]))) // [R12]
      else $error("sysref exemption not honoured");

   a_output_exempt: assert property (##1 output_resync_o == ({7{sync_assert_o}} & ~$past(exempt[6:0]))) // [R13]
      else $error("output exemption not honoured");

   a_ref_reserved: assert property (avs_read_i && avs_waitrequest_o && hit(idx, `SEC_IDX_REF)
                                    |=> avs_readdata_o[7:6] == 2'h0) // [R20]
      else $error("reserved reference bits read nonzero");

   a_ref_fields: assert property (wr_ref ##2 1'b1 |-> ref_auto_enable_o == $past(wdat[5:3], 2)
                                  || $past(wr_ref)) // [R15]
      else $error("auto enable output not following register");

   a_buffer_type: assert property (!srst_i |=> ref_buffer_cmos_o
                                   == $past(ref_ctrl[`SEC_TYPE_MSB:`SEC_TYPE_LSB])) // [R16]
      else $error("buffer type output not following register");

   a_pin_two_stage: assert property (!srst_i |-> ##2 (pin_sam == $past(sync_pin_i, 2))) // [R19]
      else $error("sync pin not passed through two stages");

   a_power_block: assert property (pwr_ctrl[`SEC_B_PD] |=> !sync_assert_o && !pulser_start_o) // [R18]
      else $error("sync event while sysref circuitry powered down");

   a_pin_no_pulse: assert property (src == SEC_SRC_PIN |=> !pulser_start_o) // [R9]
      else $error("pin source started the pulser");

   a_pulse_one_cycle: assert property (pulser_start_o |=> !pulser_start_o) // [R10]
      else $error("pulser start longer than one cycle");

endmodule : sec_top
